//--- logic/ccp_pkg.sv
/*
  Shared constants and types of the camera capture and pixel pipeline:
  register offsets and fields, reset values, frame geometry, timing
  counts, the factory defect map, pipeline stage types and FSM states.
  Assumes one system clock, aclk, at 250 MHz.
*/
package ccp_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int PIX_W      = 12;
  localparam int OUT_W      = 8;
  localparam int LUT_DEPTH  = 4096;
  localparam int DEF_N      = 16;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_EXP    = 8'h04;
  localparam logic [7:0] REG_RODLY  = 8'h08;
  localparam logic [7:0] REG_AOI    = 8'h0c;
  localparam logic [7:0] REG_DEFECT = 8'h10;
  localparam logic [7:0] REG_LUT    = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_DPC_BIT  = 1;
  localparam int CTRL_MAP_BIT  = 2;
  localparam int CTRL_SOFT_BIT = 3;

  localparam int DEF_X_LSB     = 0;
  localparam int DEF_Y_LSB     = 12;
  localparam int DEF_IDX_LSB   = 24;
  localparam int DEF_VALID_BIT = 31;
  localparam int LUT_DATA_LSB  = 0;
  localparam int LUT_ADDR_LSB  = 8;
  localparam int AOI_FIRST_LSB = 0;
  localparam int AOI_COUNT_LSB = 16;
  localparam int STAT_FV_BIT   = 0;
  localparam int STAT_EXP_BIT  = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_FRM_LSB  = 16;

  localparam logic [3:0]  CTRL_RST      = 4'h2;
  localparam logic [31:0] EXP_RST       = 32'h0000_2710;
  localparam logic [31:0] RODLY_RST     = 32'h0000_0000;
  localparam logic [11:0] AOI_FIRST_RST = 12'h000;
  localparam logic [11:0] AOI_COUNT_RST = 12'h400;

  localparam logic [11:0] COL_LAST   = 12'h3ff;
  localparam logic [7:0]  BLANK_LAST = 8'h0f;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // durations count whole aclk periods
  localparam int SYS_CLK_NS    = 4;
  localparam int TRIG_DELAY_NS = 60;
  localparam int TRIG_DLY_CYC  =
    (TRIG_DELAY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  typedef struct packed {
    logic        valid;
    logic [11:0] y;
    logic [11:0] x;
  } ccp_defect_t;

  typedef ccp_defect_t [DEF_N-1:0] ccp_dmap_t;

  // factory map: lone edge defect, a five pixel run and one lone inner defect
  localparam ccp_dmap_t FACTORY_MAP = {
    {9{25'h0000000}},
    {1'b1, 12'h020, 12'h044},
    {1'b1, 12'h010, 12'h105},
    {1'b1, 12'h010, 12'h104},
    {1'b1, 12'h010, 12'h103},
    {1'b1, 12'h010, 12'h102},
    {1'b1, 12'h010, 12'h101},
    {1'b1, 12'h005, 12'h000}
  };

  typedef struct packed {
    logic        valid;
    logic        fv;
    logic [11:0] row;
    logic [11:0] col;
    logic [11:0] raw;
  } ccp_pix_t;

  typedef enum logic [2:0] {
    EX_IDLE, EX_ALIGN, EX_SHORT, EX_ON, EX_RODLY, EX_WAIT_RO
  } ccp_ex_st_t;

  typedef enum logic [1:0] {
    RD_IDLE, RD_LINE, RD_BLANK
  } ccp_rd_st_t;

endpackage

//--- logic/ccp_lut.sv
/*
  Look-up table memory of the pixel pipeline: 4096 words of 8 bits,
  one write port for configuration and one registered read port.
  Assumes writes and reads share aclk; read data follows one edge later.
*/
`timescale 1ns/1ps
module ccp_lut
  import ccp_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             wr_en,
  input  wire logic [PIX_W-1:0] wr_addr,
  input  wire logic [OUT_W-1:0] wr_data,
  input  wire logic [PIX_W-1:0] rd_addr,
  output logic      [OUT_W-1:0] rd_data
);

  typedef struct packed {
    logic [OUT_W-1:0] q;
  } ccp_lut_st_t;

  logic [OUT_W-1:0] mem [LUT_DEPTH];
  ccp_lut_st_t      s;
  ccp_lut_st_t      next_s;

  always_comb begin
    next_s   = s;
    next_s.q = mem[rd_addr];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = s.q;

endmodule // ccp_lut

//--- logic/ccp_top.sv
/*
  Camera capture and pixel pipeline: exposure control in free-run and
  pulse-width trigger modes, readout delay, area-of-interest line
  readout with line/frame valid flags, defect pixel repair and an
  8-bit output look-up table, all set up over an AXI4-Lite slave.
  Assumes the sensor returns the pixel at sensor_row/sensor_col in the
  same cycle, and trig_in is synchronous to aclk.
*/
`timescale 1ns/1ps

module ccp_top
  import ccp_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  trig_in,
  input  wire logic [PIX_W-1:0]      sensor_pixel,
  output logic [11:0]                sensor_row,
  output logic [11:0]                sensor_col,
  output logic                       sensor_expose,
  output logic [OUT_W-1:0]           pix_out,
  output logic                       line_valid_flag,
  output logic                       frame_valid_flag
);

  typedef struct packed {
    logic        aw_rdy;
    logic        w_rdy;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        ar_rdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  ctrl;
    logic [31:0] exp_time;
    logic [31:0] ro_delay;
    logic [11:0] aoi_first;
    logic [11:0] aoi_count;
    ccp_dmap_t   cmap;
    logic        lut_we;
    logic [11:0] lut_addr;
    logic [7:0]  lut_data;
    logic        trig_prev;
    ccp_ex_st_t  ex_st;
    logic [31:0] ex_cnt;
    logic        expose;
    ccp_rd_st_t  rd_st;
    logic [11:0] row;
    logic [11:0] col;
    logic [11:0] lines_left;
    logic [7:0]  blank_cnt;
    logic        frame_valid_flag_i;
    logic        line_prev;
    logic [15:0] frame_cnt;
    ccp_pix_t    p0;
    ccp_pix_t    p1;
    logic [11:0] last_good;
    logic        lv_o;
    logic        fv_o;
  } ccp_st_t;

  ccp_st_t     s;
  ccp_st_t     next_s;
  logic [11:0] corr;
  logic        trig_now;
  logic        trig_rise;
  logic        trig_fall;
  logic        line_now;
  logic        line_valid_flag_fall;
  logic        start_req;
  logic        ro_start;
  logic        hit;
  logic [7:0]  wa;
  logic [7:0]  ra;
  logic [31:0] wv;
  logic [31:0] rd_w;
  logic        rd_ok;
  logic        wr_ok;
  logic [3:0]  didx;

  function automatic logic [31:0] merge32(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic map_hit(input ccp_dmap_t   m,
                                   input logic [11:0] x,
                                   input logic [11:0] y);
    logic h;
    h = 1'b0;
    for (int i = 0; i < DEF_N; i++) begin
      if (m[i].valid && m[i].x == x && m[i].y == y) begin
        h = 1'b1;
      end
    end
    return h;
  endfunction

  always_comb begin
    next_s    = s;
    wa        = {s.awaddr[7:2], 2'b00};
    ra        = {s_axi_araddr[7:2], 2'b00};
    wv        = 32'h0000_0000;
    rd_w      = 32'h0000_0000;
    rd_ok     = 1'b1;
    wr_ok     = 1'b1;
    didx      = 4'h0;
    ro_start  = 1'b0;
    start_req = 1'b0;

    // write channels taken independently, answered once both are held
    if (s_axi_awvalid && s.aw_rdy) begin
      next_s.aw_have = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
      next_s.aw_rdy  = 1'b0;
    end
    if (s_axi_wvalid && s.w_rdy) begin
      next_s.w_have = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
      next_s.w_rdy  = 1'b0;
    end
    next_s.lut_we = 1'b0;
    if (s.aw_have && s.w_have && !s.bvalid) begin
      case (wa)
        REG_CTRL: begin
          wv          = merge32({28'h0000000, s.ctrl}, s.wdata, s.wstrb);
          next_s.ctrl = wv[3:0];
        end
        REG_EXP: begin
          next_s.exp_time = merge32(s.exp_time, s.wdata, s.wstrb);
        end
        REG_RODLY: begin
          next_s.ro_delay = merge32(s.ro_delay, s.wdata, s.wstrb);
        end
        REG_AOI: begin
          wv = merge32({4'h0, s.aoi_count, 4'h0, s.aoi_first},
                       s.wdata, s.wstrb);
          next_s.aoi_first = wv[AOI_FIRST_LSB +: 12];
          next_s.aoi_count = wv[AOI_COUNT_LSB +: 12];
        end
        REG_DEFECT: begin
          didx = s.wdata[DEF_IDX_LSB +: 4];
          next_s.cmap[didx].valid = s.wdata[DEF_VALID_BIT];
          next_s.cmap[didx].y     = s.wdata[DEF_Y_LSB +: 12];
          next_s.cmap[didx].x     = s.wdata[DEF_X_LSB +: 12];
        end
        REG_LUT: begin
          next_s.lut_we   = 1'b1;
          next_s.lut_addr = s.wdata[LUT_ADDR_LSB +: 12];
          next_s.lut_data = s.wdata[LUT_DATA_LSB +: 8];
        end
        REG_STATUS: begin
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_rdy = 1'b1;
      next_s.w_rdy  = 1'b1;
    end

    // read: one word answered the cycle after the address is taken
    case (ra)
      REG_CTRL:   rd_w = {28'h0000000, s.ctrl};
      REG_EXP:    rd_w = s.exp_time;
      REG_RODLY:  rd_w = s.ro_delay;
      REG_AOI:    rd_w = {4'h0, s.aoi_count, 4'h0, s.aoi_first};
      REG_DEFECT: rd_w = 32'h0000_0000;
      REG_LUT:    rd_w = 32'h0000_0000;
      REG_STATUS: begin
        rd_w[STAT_FV_BIT]        = s.frame_valid_flag_i;
        rd_w[STAT_EXP_BIT]       = s.expose;
        rd_w[STAT_BUSY_BIT]      = (s.ex_st != EX_IDLE);
        rd_w[STAT_FRM_LSB +: 16] = s.frame_cnt;
      end
      default:    rd_ok = 1'b0;
    endcase
    if (s_axi_arvalid && s.ar_rdy) begin
      next_s.ar_rdy = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_w;
      next_s.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.ar_rdy = 1'b1;
    end

    // trigger edges; software level ORed with the hardware pin
    trig_now  = trig_in | s.ctrl[CTRL_SOFT_BIT];
    trig_rise = trig_now && !s.trig_prev;
    trig_fall = !trig_now && s.trig_prev;
    next_s.trig_prev = trig_now;
    line_now  = (s.rd_st == RD_LINE);
    line_valid_flag_fall = s.line_prev && !line_now;
    next_s.line_prev = line_now;

    // exposure sequencer
    case (s.ex_st)
      EX_IDLE: begin
        start_req = s.ctrl[CTRL_MODE_BIT] ? trig_rise : 1'b1;
        if (start_req) begin
          next_s.ex_cnt = 32'h0000_0000;
          if (s.frame_valid_flag_i) begin
            next_s.ex_st = EX_ALIGN;
          end else begin
            next_s.ex_st = EX_SHORT;
          end
        end
      end
      EX_ALIGN: begin
        if (s.ctrl[CTRL_MODE_BIT] && trig_fall) begin
          next_s.ex_st = EX_RODLY;
        end else if (line_valid_flag_fall) begin
          next_s.ex_st = EX_ON;
        end
      end
      EX_SHORT: begin
        next_s.ex_cnt = s.ex_cnt + 32'h0000_0001;
        if (s.ctrl[CTRL_MODE_BIT] && trig_fall) begin
          next_s.ex_st  = EX_RODLY;
          next_s.ex_cnt = 32'h0000_0000;
        end else if (s.ex_cnt == 32'(TRIG_DLY_CYC - 1)) begin
          next_s.ex_st  = EX_ON;
          next_s.ex_cnt = 32'h0000_0000;
        end
      end
      EX_ON: begin
        next_s.ex_cnt = s.ex_cnt + 32'h0000_0001;
        if (s.ctrl[CTRL_MODE_BIT]) begin
          if (trig_fall) begin
            next_s.ex_st  = EX_RODLY;
            next_s.ex_cnt = 32'h0000_0000;
          end
        end else if (s.ex_cnt + 32'h0000_0001 >= s.exp_time) begin
          next_s.ex_st  = EX_RODLY;
          next_s.ex_cnt = 32'h0000_0000;
        end
      end
      EX_RODLY: begin
        if (s.ex_cnt >= s.ro_delay) begin
          next_s.ex_st = EX_WAIT_RO;
        end else begin
          next_s.ex_cnt = s.ex_cnt + 32'h0000_0001;
        end
      end
      EX_WAIT_RO: begin
        if (s.rd_st == RD_IDLE) begin
          ro_start     = 1'b1;
          next_s.ex_st = EX_IDLE;
        end
      end
      default: next_s.ex_st = EX_IDLE;
    endcase
    next_s.expose = (next_s.ex_st == EX_ON);

    // readout of the selected band of lines
    case (s.rd_st)
      RD_IDLE: begin
        if (ro_start && s.aoi_count != 12'h000) begin
          next_s.row        = s.aoi_first;
          next_s.lines_left = s.aoi_count;
          next_s.col        = 12'h000;
          next_s.frame_valid_flag_i     = 1'b1;
          next_s.rd_st      = RD_LINE;
        end
      end
      RD_LINE: begin
        next_s.col = s.col + 12'h001;
        if (s.col == COL_LAST) begin
          next_s.rd_st     = RD_BLANK;
          next_s.blank_cnt = 8'h00;
        end
      end
      RD_BLANK: begin
        next_s.blank_cnt = s.blank_cnt + 8'h01;
        if (s.blank_cnt == BLANK_LAST) begin
          if (s.lines_left == 12'h001) begin
            next_s.rd_st     = RD_IDLE;
            next_s.frame_valid_flag_i    = 1'b0;
            next_s.frame_cnt = s.frame_cnt + 16'h0001;
          end else begin
            next_s.row        = s.row + 12'h001;
            next_s.lines_left = s.lines_left - 12'h001;
            next_s.col        = 12'h000;
            next_s.rd_st      = RD_LINE;
          end
        end
      end
      default: next_s.rd_st = RD_IDLE;
    endcase

    // pixel pipeline: capture, repair, table look-up
    next_s.p0.valid = line_now;
    next_s.p0.fv    = s.frame_valid_flag_i;
    next_s.p0.row   = s.row;
    next_s.p0.col   = s.col;
    next_s.p0.raw   = sensor_pixel;
    next_s.p1       = s.p0;
    hit = s.ctrl[CTRL_DPC_BIT] && s.p1.valid &&
          map_hit(s.ctrl[CTRL_MAP_BIT] ? s.cmap : FACTORY_MAP,
                  s.p1.col, s.p1.row);
    if (!hit) begin
      corr = s.p1.raw;
    end else if (s.p1.col == 12'h000) begin
      corr = s.p0.raw;
    end else begin
      corr = s.last_good;
    end
    if (s.p1.valid) begin
      next_s.last_good = corr;
    end
    next_s.lv_o = s.p1.valid;
    next_s.fv_o = s.p1.fv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s           <= '0;
      s.aw_rdy    <= 1'b1;
      s.w_rdy     <= 1'b1;
      s.ar_rdy    <= 1'b1;
      s.ctrl      <= CTRL_RST;
      s.exp_time  <= EXP_RST;
      s.ro_delay  <= RODLY_RST;
      s.aoi_first <= AOI_FIRST_RST;
      s.aoi_count <= AOI_COUNT_RST;
      s.ex_st     <= EX_IDLE;
      s.rd_st     <= RD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  ccp_lut u_lut (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (s.lut_we),
    .wr_addr (s.lut_addr),
    .wr_data (s.lut_data),
    .rd_addr (corr),
    .rd_data (pix_out)
  );

  assign s_axi_awready    = s.aw_rdy;
  assign s_axi_wready     = s.w_rdy;
  assign s_axi_bvalid     = s.bvalid;
  assign s_axi_bresp      = s.bresp;
  assign s_axi_arready    = s.ar_rdy;
  assign s_axi_rvalid     = s.rvalid;
  assign s_axi_rdata      = s.rdata;
  assign s_axi_rresp      = s.rresp;
  assign sensor_row       = s.row;
  assign sensor_col       = s.col;
  assign sensor_expose    = s.expose;
  assign line_valid_flag  = s.lv_o;
  assign frame_valid_flag = s.fv_o;

endmodule // ccp_top

//--- dv/ccp_sensor_model.sv
/*
  Sensor and trigger source model for ccp_top.
  Assumes pixel data is a pure function of row and column, same cycle.
*/
`timescale 1ns/1ps
module ccp_sensor_model
  import ccp_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             trig_req,
  input  wire logic             frame_valid_flag,
  input  wire logic [11:0]      sensor_row,
  input  wire logic [11:0]      sensor_col,
  output logic                  trig_in,
  output logic      [PIX_W-1:0] sensor_pixel
);
  assign sensor_pixel = 12'({sensor_row[7:0], 4'h0} + sensor_col);
  // trigger drops once trig_req is low and no frame is valid
  always_ff @(posedge aclk)
    if (!aresetn) trig_in <= 1'h0;
    else if (trig_req) trig_in <= 1'h1;
    else if (!frame_valid_flag) trig_in <= 1'h0;
endmodule // ccp_sensor_model

//--- dv/ccp_top_asserts.sv
/*
  Checker for ccp_top ports: bus answers, line and frame flags, trigger.
  Assumes it is bound into ccp_top, single clock aclk.
*/
`timescale 1ns/1ps
module ccp_top_chk
  import ccp_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        trig_in,
  input wire logic        sensor_expose,
  input wire logic        line_valid_flag,
  input wire logic        frame_valid_flag
);
  localparam int DLO = TRIG_DLY_CYC;
  localparam int DHI = TRIG_DLY_CYC + 3;
  logic [10:0] lv_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk)
    if (!aresetn) lv_cnt <= 11'h000;
    else lv_cnt <= line_valid_flag ? lv_cnt + 11'h001 : 11'h000;
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_line_in_frame: assert property (
    line_valid_flag |-> frame_valid_flag) else $error("line outside frame");
  a_line_length: assert property (
    $fell(line_valid_flag) |-> lv_cnt == 11'h400) else $error("line len");
  a_frame_start: assert property (
    $rose(frame_valid_flag) |-> line_valid_flag) else $error("frame start");
  a_frame_end: assert property (
    $fell(frame_valid_flag) |-> $past(line_valid_flag, 17) &&
    !$past(line_valid_flag, 16)) else $error("fend");
  a_trig_delay: assert property (
    $rose(trig_in) && !frame_valid_flag && !sensor_expose |->
    ##[DLO:DHI] $rose(sensor_expose)) else $error("trigger delay");
  a_trig_end: assert property (
    $fell(trig_in) && sensor_expose |-> ##[1:2] !sensor_expose)
    else $error("exposure not ended");
  a_overlap_align: assert property (
    $rose(sensor_expose) && frame_valid_flag |-> ##[0:2]
    $fell(line_valid_flag)) else $error("exposure not line aligned");
endmodule // ccp_top_chk

bind ccp_top ccp_top_chk ccp_top_chk_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .trig_in,
  .sensor_expose, .line_valid_flag, .frame_valid_flag);

//--- dv/ccp_top_test.sv
/*
  Self-checking bench for ccp_top: registers, lut, trigger and free run.
  Assumes ccp_sensor_model as sensor and trigger source.
*/
`timescale 1ns/1ps
module ccp_top_test
  import ccp_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, trig_req = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pix_out;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sensor_expose, line_valid_flag, frame_valid_flag;
  logic trig_in;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] sensor_pixel, sensor_row, sensor_col, prev, rv;
  logic [7:0] lut_m [LUT_DEPTH];
  logic [15:0] seed = 16'h003f;
  ccp_dmap_t cmap_m = '0;
  ccp_defect_t e;
  int miscompares, samples_checked, frames, cyc, row_m, col_m, first_m;
  int cnt_m, ecnt, ewid, estart, trise, efall, fstart, ovl_n, t;
  int w [2], d [2], ro [2];
  bit dpc_m = 1, map_m = 0, lvd, fvd, ed, td;

  always #2 aclk = ~aclk;

  ccp_top ccp_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_in, .sensor_pixel,
    .sensor_row, .sensor_col, .sensor_expose, .pix_out, .line_valid_flag,
    .frame_valid_flag);
  ccp_sensor_model ccp_sensor_model_inst (.aclk, .aresetn, .trig_req,
    .frame_valid_flag, .sensor_row, .sensor_col, .trig_in, .sensor_pixel);

  task bad(input string m);
    miscompares++;
    $display("Error %0t: %s", $time, m);
  endtask
  task cmp_reg(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) bad($sformatf("reg %h exp %h", g, x));
  endtask
  task cmp_pix(input logic [7:0] g, input logic [7:0] x);
    samples_checked++;
    if (g !== x) bad($sformatf("pix %h exp %h r%0d c%0d", g, x, row_m, col_m));
  endtask
  task cmp_cnt(input int g, input int x);
    samples_checked++;
    if (g != x) bad($sformatf("count %0d exp %0d", g, x));
  endtask
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic [11:0] raw(input int r, input int c);
    return 12'((r << 4) + c);
  endfunction
  function bit isdef(input int r, input int c);
    ccp_dmap_t m;
    m = map_m ? cmap_m : FACTORY_MAP;
    isdef = 0;
    for (int i = 0; i < DEF_N; i++)
      if (dpc_m && m[i].valid && m[i].y == r && m[i].x == c) isdef = 1;
  endfunction

  // slave outputs are read at the falling edge, settled before the rise
  task axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    bit ar, wr, bv;
    logic [1:0] br;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(negedge aclk);
      {ar, wr, bv, br} = {s_axi_awready, s_axi_wready, s_axi_bvalid,
                          s_axi_bresp};
      @(posedge aclk);
      if (s_axi_awvalid && ar) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && wr) s_axi_wvalid <= 1'h0;
      if (bv) begin
        s_axi_bready <= 1'h0;
        cmp_reg({30'h0, br}, {30'h0, er});
        break;
      end
    end
    @(posedge aclk);
  endtask
  task axr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    bit ar, rv_s;
    logic [31:0] rd;
    logic [1:0] rr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(negedge aclk);
      {ar, rv_s, rd, rr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata,
                            s_axi_rresp};
      @(posedge aclk);
      if (s_axi_arvalid && ar) s_axi_arvalid <= 1'h0;
      if (rv_s) begin
        s_axi_rready <= 1'h0;
        cmp_reg(rd, x);
        cmp_reg({30'h0, rr}, {30'h0, er});
        break;
      end
    end
    @(posedge aclk);
  endtask
  task trig(input int n);
    trig_req <= 1'h1;
    repeat (n) @(posedge aclk);
    trig_req <= 1'h0;
    @(posedge aclk);
  endtask
  task wf(input int n);
    int g;
    g = frames + n;
    for (t = 0; t < 20000 && frames < g; t++) @(posedge aclk);
    if (frames < g) bad("no frame");
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // pixel, line, frame and exposure monitor
  always @(negedge aclk) if (aresetn) begin
    if (line_valid_flag) begin
      rv = raw(row_m, col_m);
      if (isdef(row_m, col_m)) rv = (col_m == 0) ? raw(row_m, 1) : prev;
      prev = rv;
      cmp_pix(pix_out, lut_m[rv]);
      col_m++;
    end else if (lvd) begin
      cmp_cnt(col_m, 1024);
      row_m++;
      col_m = 0;
    end
    if (fvd && !frame_valid_flag) begin
      cmp_cnt(row_m - first_m, cnt_m);
      row_m = first_m;
      frames++;
    end
    if (sensor_expose) ecnt++;
    if (!sensor_expose && ed) ewid = ecnt;
    if (!sensor_expose && ed) efall = cyc;
    if (!sensor_expose) ecnt = 0;
    if (sensor_expose && !ed) estart = cyc;
    if (sensor_expose && !ed && frame_valid_flag) ovl_n++;
    if (frame_valid_flag && !fvd) fstart = cyc;
    if (trig_in && !td) trise = cyc;
    {lvd, fvd, ed, td} = {line_valid_flag, frame_valid_flag,
                          sensor_expose, trig_in};
    cyc++;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(REG_CTRL, {28'h0, CTRL_RST}, RESP_OKAY);
    axr(REG_EXP, EXP_RST, RESP_OKAY);
    axr(REG_RODLY, RODLY_RST, RESP_OKAY);
    axr(REG_AOI, {4'h0, AOI_COUNT_RST, 4'h0, AOI_FIRST_RST}, RESP_OKAY);
    axr(8'h1c, 32'h0, RESP_SLVERR);
    axr(REG_LUT, 32'h0, RESP_OKAY);
    axw(REG_AOI, 32'h0, RESP_OKAY);
    axw(8'h20, 32'h0, RESP_SLVERR);
    axw(REG_CTRL, 32'h3, RESP_OKAY);
    for (int i = 0; i < LUT_DEPTH; i++) begin
      seed = lfsr(seed);
      lut_m[i] = seed[7:0];
      axw(REG_LUT, {12'h0, 12'(i), seed[7:0]}, RESP_OKAY);
    end
    first_m = 15;
    cnt_m = 2;
    row_m = 15;
    axw(REG_AOI, 32'h0002000f, RESP_OKAY);
    // ends the exposure left open by the free run after reset
    trig(40);
    wf(1);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      axw(REG_RODLY, k ? 32'h14 : 32'h7, RESP_OKAY);
      trig(k ? 90 : 40);
      wf(1);
      w[k] = ewid;
      d[k] = estart - trise;
      ro[k] = fstart - efall;
    end
    cmp_cnt(w[1] - w[0], 50);
    cmp_cnt(d[1], d[0]);
    cmp_cnt(d[0], TRIG_DLY_CYC + 1);
    cmp_cnt(ro[1] - ro[0], 13);
    $display("test pulse width done");
    trig(40);
    for (t = 0; t < 9000 && !line_valid_flag; t++) @(negedge aclk);
    @(posedge aclk);
    trig(10);
    wf(2);
    cmp_cnt(ovl_n, 1);
    $display("test overlap done");
    axw(REG_CTRL, 32'hb, RESP_OKAY);
    repeat (40) @(posedge aclk);
    axw(REG_CTRL, 32'h3, RESP_OKAY);
    wf(1);
    $display("test soft trigger done");
    for (int k = 0; k < 2; k++) begin
      e = {1'h1, 12'h00f, k ? 12'h3ff : 12'h000};
      cmap_m[k] = e;
      axw(REG_DEFECT, {1'h1, 3'h0, 4'(k), e[23:0]}, RESP_OKAY);
    end
    axw(REG_CTRL, 32'h7, RESP_OKAY);
    map_m = 1;
    trig(40);
    wf(1);
    axw(REG_CTRL, 32'h5, RESP_OKAY);
    dpc_m = 0;
    trig(40);
    wf(1);
    axr(REG_STATUS, 32'(frames) << 16, RESP_OKAY);
    $display("test defect maps done");
    axw(REG_EXP, 32'h14, RESP_OKAY);
    axw(REG_CTRL, 32'h2, RESP_OKAY);
    dpc_m = 1;
    map_m = 0;
    wf(3);
    cmp_cnt(ewid, 20);
    $display("test free run done");
    close_out;
  end

  initial begin
    #400000;
    bad("timeout");
    close_out;
  end
endmodule // ccp_top_test
